// >>> include/ocs_pkg.sv
// Constants and carrier types of the oscillator clock source switch.
// Assumes a 250 MHz system clock; every clock is a sampled level.
`default_nettype none

package ocs_pkg;

    // Source select codes
    localparam logic [1:0] SRC_INT  = 2'h0;
    localparam logic [1:0] SRC_EXT  = 2'h1;
    localparam logic [1:0] SRC_RC   = 2'h2;
    localparam logic [1:0] SRC_XTAL = 2'h3;

    // Internal frequency codes
    localparam logic [1:0] IFS_4M   = 2'h0;
    localparam logic [1:0] IFS_8M   = 2'h1;
    localparam logic [1:0] IFS_12M8 = 2'h2;
    localparam logic [1:0] IFS_RSVD = 2'h3;

    // Crystal range codes, one amplifier each
    localparam logic [1:0] XR_8M_32M    = 2'h0;
    localparam logic [1:0] XR_1M_8M     = 2'h1;
    localparam logic [1:0] XR_32K_100K  = 2'h2;
    localparam int         XR_AMPS      = 3;

    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
    localparam int F_4M_KHZ      = 4000;
    localparam int F_8M_KHZ      = 8000;
    localparam int F_12M8_KHZ    = 12800;
    localparam int NCO_W         = 32;
    localparam logic [31:0] INC_4M   =
        32'((64'(F_4M_KHZ) << NCO_W) / CLK_KHZ);
    localparam logic [31:0] INC_8M   =
        32'((64'(F_8M_KHZ) << NCO_W) / CLK_KHZ);
    localparam logic [31:0] INC_12M8 =
        32'((64'(F_12M8_KHZ) << NCO_W) / CLK_KHZ);

    // Trim: one step is about 0.2 percent of the period
    localparam int         TRIM_SHIFT  = 9;
    localparam logic [8:0] TRIM_CENTRE = 9'h080;

    // External rising edges seen before handover
    localparam logic [1:0] EXT_EDGES = 2'h2;

    typedef struct packed {
        logic [1:0] source_select;
        logic [1:0] crystal_range_select;
        logic [1:0] internal_frequency_select;
        logic [7:0] internal_trim_value;
        logic       external_clock_request;
        logic       secondary_pin_clock_out_enable;
    } ocs_cfg_t;

    typedef struct packed {
        logic external_clock_engaged;
        logic internal_osc_running;
        logic clock_out_enable_effective;
    } ocs_stat_t;

    // Reset values
    localparam ocs_cfg_t CFG_RST = '{
        source_select:                  SRC_INT,
        crystal_range_select:           XR_8M_32M,
        internal_frequency_select:      IFS_12M8,
        internal_trim_value:            8'h80,
        external_clock_request:         1'b0,
        secondary_pin_clock_out_enable: 1'b0
    };
    localparam logic [31:0] INC_RST = INC_12M8;

endpackage

`default_nettype wire

// >>> src/ocs_clock_divider.sv
// Divides the times-four clock level into times-two and bus clock levels.
// Assumes the times-four level is registered in the clk_in domain.
`timescale 1ns/1ps
`default_nettype none

module ocs_clock_divider
(
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic ce_in,
    input  wire logic times_four_in,
    output logic      times_two_out,
    output logic      bus_clock_out
);

    logic four_prev_q;
    logic two_prev_q;
    logic four_rise;
    logic two_rise;

    assign four_rise = times_four_in & ~four_prev_q;
    assign two_rise  = times_two_out & ~two_prev_q;

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            four_prev_q   <= 1'b0;
            two_prev_q    <= 1'b0;
            times_two_out <= 1'b0;
            bus_clock_out <= 1'b0;
        end
        else if (ce_in)
        begin
            four_prev_q <= times_four_in;
            two_prev_q  <= times_two_out;
            if (four_rise)
                times_two_out <= ~times_two_out; // R05
            if (two_rise)
                bus_clock_out <= ~bus_clock_out; // R01
        end
    end

    half_rate_a : // R05
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ce_in && four_rise) |=> (times_two_out != $past(times_two_out)))
    else $error("times-two did not toggle on times-four rise");

    quarter_rate_a : // R01
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ce_in && !four_rise && !two_rise) |=>
        $stable(times_two_out) && $stable(bus_clock_out))
    else $error("derived clock moved without a source edge");

endmodule

`default_nettype wire

// >>> src/ocs_clock_switch.sv
// Clock source selection, internal oscillator model and handover logic.
// Assumes pins and source clock levels arrive synchronous to clk_in and
// the configuration word is held by a software register outside.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01 - Bus clock runs at one quarter of the selected source.
// R02 - Internal oscillator offers 12.8, 8 and 4 MHz; 12.8 after reset.
// R03 - Three crystal ranges, each with its own selectable amplifier.
// R04 - Times-four clock equals source; feeds system unit and watchdog.
// R05 - Times-two clock is half of times-four, sent to system unit.
// R06 - Stop-mode enable gates oscillators unless keep-in-stop is set.
// R07 - Trim adjusts period by +127..-128 steps; larger means slower.
// R08 - Software copies factory trim into trim value when wanted.
// R09 - Software sets select and range, waits, then sets request.
// R10 - Software should wait about 4096 crystal cycles first.
// R11 - External source enables primary pin input; crystal drives second.
// R12 - After request, wait two external rising edges, switch glitch-free.
// R13 - Engaged status rises first, internal oscillator stops after.
// R14 - Clearing select and request returns to internal frequency.
// R15 - External clock mode forces secondary clock-out enable clear.
// R16 - Crystal mode dedicates secondary pin; clock-out enable ignored.
// R17 - RC mode drives clock out on secondary pin when enabled.
// R18 - Internal mode drives times-four on secondary pin when enabled.
// R19 - The block raises no interrupt requests.
// R20 - Block keeps running and delivering clocks in wait mode.
// R21 - Select codes internal, external, RC, crystal; internal at reset.
// R22 - Frequency codes 4, 8, 12.8 MHz; 12.8 at reset; 11 reserved.
// R23 - Range codes select amplifier; code 11 reserved.
// R24 - Reset clears request; engaged is read-only external status.
// R25 - Returning: restart internal, clear engaged, then release external.
module ocs_clock_switch
(
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              ce_in,
    input  wire ocs_pkg::ocs_cfg_t cfg_in,
    input  wire logic              stop_oscillator_enable_in,
    input  wire logic              keep_oscillator_in_stop_in,
    input  wire logic              primary_oscillator_pin_in,
    input  wire logic              crystal_clock_in,
    input  wire logic              resistor_capacitor_clock_in,
    output ocs_pkg::ocs_stat_t     status_out,
    output logic                   bus_clock_times_four_out,
    output logic                   bus_clock_times_two_out,
    output logic                   bus_clock_out,
    output logic                   primary_pin_clock_input_en_out,
    output logic [2:0]             crystal_amp_enable_out,
    output logic                   rc_osc_enable_out,
    output logic                   secondary_oscillator_pin_out,
    output logic                   secondary_oscillator_pin_oe_out
);

    typedef enum logic [4:0] {
        ST_INT   = 5'b00001,
        ST_COUNT = 5'b00010,
        ST_HAND  = 5'b00100,
        ST_EXT   = 5'b01000,
        ST_BACK  = 5'b10000
    } ocs_state_t;

    ocs_pkg::ocs_cfg_t cfg_q;
    ocs_state_t        state_q;
    logic [31:0]       inc_q;
    logic [31:0]       inc_d;
    logic [31:0]       base_inc;
    logic [31:0]       acc_q;
    logic signed [8:0] trim_step;
    logic signed [41:0] trim_prod;
    logic              osc_allowed;
    logic              int_run;
    logic              int_lvl;
    logic              ext_raw;
    logic              ext_lvl_q;
    logic              ext_prev_q;
    logic              ext_rise;
    logic [1:0]        edge_cnt_q;
    logic              sel_ext_q;
    logic              engaged_q;
    logic              int_stop_q;
    logic              want_ext;
    logic              want_int;
    logic              both_low;
    logic              clk_out_en;

    // Config word with documented reset values
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cfg_q <= ocs_pkg::CFG_RST; // R21 R22 R24 R02
        else if (ce_in)
            cfg_q <= cfg_in;
    end
    assign osc_allowed = stop_oscillator_enable_in
                       | keep_oscillator_in_stop_in; // R06
    assign want_ext = cfg_q.external_clock_request
                    & (cfg_q.source_select != ocs_pkg::SRC_INT);
    assign want_int = ~cfg_q.external_clock_request
                    & (cfg_q.source_select == ocs_pkg::SRC_INT); // R14
    // Internal oscillator: phase accumulator with trim
    always_comb
    begin
        unique case (cfg_q.internal_frequency_select)
            ocs_pkg::IFS_4M:   base_inc = ocs_pkg::INC_4M;
            ocs_pkg::IFS_8M:   base_inc = ocs_pkg::INC_8M;
            ocs_pkg::IFS_12M8: base_inc = ocs_pkg::INC_12M8;
            ocs_pkg::IFS_RSVD: base_inc = inc_q;
        endcase
    end

    assign trim_step = $signed({1'b0, cfg_q.internal_trim_value})
                     - $signed(ocs_pkg::TRIM_CENTRE);
    assign trim_prod = $signed({1'b0, base_inc >> ocs_pkg::TRIM_SHIFT})
                     * trim_step;
    assign inc_d     = base_inc - trim_prod[31:0]; // R07
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            inc_q <= ocs_pkg::INC_RST; // R02
        else if (ce_in && cfg_q.internal_frequency_select != ocs_pkg::IFS_RSVD)
            inc_q <= inc_d; // R22
    end
    assign int_run = ~int_stop_q & osc_allowed; // R06 R20
    assign int_lvl = acc_q[31];
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            acc_q <= 32'h00000000;
        else if (ce_in)
            acc_q <= int_run ? acc_q + inc_q : 32'h00000000;
    end
    // External source level and its rising edges
    always_comb
    begin
        unique case (cfg_q.source_select)
            ocs_pkg::SRC_INT:  ext_raw = 1'b0;
            ocs_pkg::SRC_EXT:  ext_raw = primary_oscillator_pin_in;
            ocs_pkg::SRC_RC:   ext_raw = resistor_capacitor_clock_in
                                       & osc_allowed; // R06
            ocs_pkg::SRC_XTAL: ext_raw = crystal_clock_in & osc_allowed;
        endcase
    end
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ext_lvl_q  <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else if (ce_in)
        begin
            ext_lvl_q  <= ext_raw;
            ext_prev_q <= ext_lvl_q;
        end
    end
    assign ext_rise = ext_lvl_q & ~ext_prev_q;
    assign both_low = ~int_lvl & ~ext_lvl_q;
    // Handover sequencer
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_q    <= ST_INT;
            edge_cnt_q <= 2'h0;
            sel_ext_q  <= 1'b0;
            engaged_q  <= 1'b0; // R24
            int_stop_q <= 1'b0;
        end
        else if (ce_in)
        begin
            unique case (state_q)
                ST_INT:
                begin
                    edge_cnt_q <= 2'h0;
                    if (want_ext)
                        state_q <= ST_COUNT; // R09
                end
                ST_COUNT:
                begin
                    if (!want_ext)
                        state_q <= ST_INT;
                    else if (edge_cnt_q == ocs_pkg::EXT_EDGES)
                        state_q <= ST_HAND; // R12
                    else if (ext_rise)
                        edge_cnt_q <= edge_cnt_q + 2'h1; // R12
                end
                ST_HAND:
                begin
                    if (!want_ext)
                        state_q <= ST_INT;
                    else if (both_low)
                    begin
                        sel_ext_q <= 1'b1; // R12
                        engaged_q <= 1'b1; // R13
                        state_q   <= ST_EXT;
                    end
                end
                ST_EXT:
                begin
                    if (want_int)
                    begin
                        int_stop_q <= 1'b0; // R25
                        engaged_q  <= 1'b0; // R25
                        state_q    <= ST_BACK;
                    end
                    else
                        int_stop_q <= 1'b1; // R13
                end
                ST_BACK:
                begin
                    if (both_low)
                    begin
                        sel_ext_q <= 1'b0; // R14 R25
                        state_q   <= ST_INT;
                    end
                end
            endcase
        end
    end
    // Times-four is the selected source level
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            bus_clock_times_four_out <= 1'b0;
        else if (ce_in)
            bus_clock_times_four_out <= sel_ext_q ? ext_lvl_q
                                                  : int_lvl; // R04
    end

    ocs_clock_divider u_div
    (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .times_four_in (bus_clock_times_four_out),
        .times_two_out (bus_clock_times_two_out),
        .bus_clock_out (bus_clock_out)
    );

    // Pin control
    assign clk_out_en = cfg_q.secondary_pin_clock_out_enable
                      & ((cfg_q.source_select == ocs_pkg::SRC_INT)
                      | (cfg_q.source_select == ocs_pkg::SRC_RC)); // R15

    assign primary_pin_clock_input_en_out =
        cfg_q.source_select != ocs_pkg::SRC_INT; // R11
    assign rc_osc_enable_out =
        (cfg_q.source_select == ocs_pkg::SRC_RC) & osc_allowed; // R06

    for (genvar i = 0; i < ocs_pkg::XR_AMPS; i++)
    begin : g_amp
        assign crystal_amp_enable_out[i] =
            (cfg_q.source_select == ocs_pkg::SRC_XTAL) & osc_allowed
            & (cfg_q.crystal_range_select == 2'(i)); // R03 R23
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            secondary_oscillator_pin_out    <= 1'b0;
            secondary_oscillator_pin_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            if (cfg_q.source_select == ocs_pkg::SRC_XTAL)
            begin
                // Amplifier output inverts the primary pin
                secondary_oscillator_pin_out    <=
                    ~primary_oscillator_pin_in; // R11 R16
                secondary_oscillator_pin_oe_out <= osc_allowed;
            end
            else
            begin
                secondary_oscillator_pin_out    <=
                    clk_out_en & (sel_ext_q ? ext_lvl_q
                                            : int_lvl); // R17 R18
                secondary_oscillator_pin_oe_out <= clk_out_en; // R15
            end
        end
    end

    // No interrupt output exists
    assign status_out.external_clock_engaged     = engaged_q; // R19 R24
    assign status_out.internal_osc_running       = int_run;
    assign status_out.clock_out_enable_effective = clk_out_en;

    engaged_first_a : // R13
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(engaged_q) |-> !int_stop_q && sel_ext_q)
    else $error("internal oscillator stopped before engaged status");
    two_edges_a : // R12
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(engaged_q) |-> $past(edge_cnt_q) == ocs_pkg::EXT_EDGES)
    else $error("engaged without two external rising edges");
    release_order_a : // R25
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(engaged_q) |-> sel_ext_q && !int_stop_q)
    else $error("external released before engaged cleared");
    stop_gate_a : // R06
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !osc_allowed |-> !int_run && !rc_osc_enable_out
                         && crystal_amp_enable_out == 3'h0)
    else $error("oscillator running in stop without override");
    ext_out_clear_a : // R15
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ce_in && cfg_q.source_select == ocs_pkg::SRC_EXT) |=>
        !secondary_oscillator_pin_oe_out)
    else $error("secondary pin driven in external clock mode");
    xtal_pin_a : // R16
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ce_in && osc_allowed
         && cfg_q.source_select == ocs_pkg::SRC_XTAL) |=>
        secondary_oscillator_pin_oe_out
        && secondary_oscillator_pin_out
           == !$past(primary_oscillator_pin_in))
    else $error("crystal amplifier output not inverting primary pin");
    clk_out_a : // R18
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ce_in && cfg_q.source_select == ocs_pkg::SRC_INT
         && cfg_q.secondary_pin_clock_out_enable && !sel_ext_q) |=>
        secondary_oscillator_pin_oe_out
        && secondary_oscillator_pin_out == bus_clock_times_four_out)
    else $error("times-four not routed to secondary pin");
    primary_in_a : // R11
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        primary_pin_clock_input_en_out
        == (cfg_q.source_select != ocs_pkg::SRC_INT))
    else $error("primary pin input enable wrong");
    int_engaged_a : // R24
    assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (state_q == ST_INT || state_q == ST_COUNT) |-> !engaged_q)
    else $error("engaged set while internal source in use");

endmodule

`default_nettype wire

// >>> tb/ocs_far_model.sv
// Far side: system unit counting derived clock edges, plus an external
// clock source. Assumes every level is sampled on clk_in.
`timescale 1ns/1ps
`default_nettype none

module ocs_far_model
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       run_in,
    input  wire logic [7:0] half_in,
    input  wire logic       clr_in,
    input  wire logic       x4_in,
    input  wire logic       x2_in,
    input  wire logic       bus_in,
    output logic            src_out,
    output var int          n_x4_out,
    output var int          n_x2_out,
    output var int          n_bus_out,
    output var int          n_src_out
);
    logic [7:0] div_q;
    logic [3:0] prev_q;
    logic [3:0] lv;
    int         cnt_q [4];

    assign lv = {src_out, bus_in, x2_in, x4_in};

    // Source stands low while not running
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            div_q   <= 8'h00;
            src_out <= 1'b0;
        end
        else if (!run_in || div_q + 8'h01 >= half_in)
        begin
            div_q   <= 8'h00;
            src_out <= run_in && !src_out;
        end
        else
            div_q <= div_q + 8'h01;
    end

    always_ff @(posedge clk_in)
    begin
        prev_q <= lv;
        for (int i = 0; i < 4; i++)
            if (clr_in)
                cnt_q[i] <= 0;
            else if (lv[i] && !prev_q[i])
                cnt_q[i] <= cnt_q[i] + 1;
    end

    assign n_x4_out  = cnt_q[0];
    assign n_x2_out  = cnt_q[1];
    assign n_bus_out = cnt_q[2];
    assign n_src_out = cnt_q[3];
endmodule

`default_nettype wire

// >>> tb/oscillator_clock_source_switch_tb.sv
// Self-checking bench of the clock source switch.
// Assumes the far-side model supplies source levels and edge counts.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g, t) \
    begin n_checks++; \
    if ((t) == 0 ? ((g) !== (e)) : ((g) > (e) + (t) || (g) + (t) < (e))) \
    begin fail_count++; \
    $display("MISMATCH %s exp=%0d got=%0d", nm, e, g); end end

module oscillator_clock_source_switch_tb;
    logic               clk_in     = 1'b0;
    logic               sys_rst_in = 1'b1;
    logic               ce_in      = 1'b1;
    logic               stop_en    = 1'b1;
    logic               keep       = 1'b0;
    logic               run        = 1'b0;
    logic               clr        = 1'b0;
    logic [7:0]         oe_exp     = 8'hE2;
    ocs_pkg::ocs_cfg_t  cfg        = ocs_pkg::CFG_RST;
    ocs_pkg::ocs_cfg_t  c          = ocs_pkg::CFG_RST;
    ocs_pkg::ocs_stat_t st;
    logic               x4, x2, bus, pen, rcen, spo, spoe, src;
    logic [2:0]         amps;
    int                 n4, n2, nb, np, k, hi, lo;
    int                 fr [3]     = '{ocs_pkg::F_4M_KHZ,
                                       ocs_pkg::F_8M_KHZ,
                                       ocs_pkg::F_12M8_KHZ};
    int                 fail_count = 0;
    int                 n_checks   = 0;

    always #2 clk_in = ~clk_in;

    ocs_clock_switch i_ocs_clock_switch (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
        .cfg_in(cfg), .stop_oscillator_enable_in(stop_en),
        .keep_oscillator_in_stop_in(keep),
        .primary_oscillator_pin_in(src), .crystal_clock_in(src),
        .resistor_capacitor_clock_in(src), .status_out(st),
        .bus_clock_times_four_out(x4), .bus_clock_times_two_out(x2),
        .bus_clock_out(bus), .primary_pin_clock_input_en_out(pen),
        .crystal_amp_enable_out(amps), .rc_osc_enable_out(rcen),
        .secondary_oscillator_pin_out(spo),
        .secondary_oscillator_pin_oe_out(spoe));

    ocs_far_model i_ocs_far_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .run_in(run),
        .half_in(8'h05), .clr_in(clr), .x4_in(x4), .x2_in(x2),
        .bus_in(bus), .src_out(src), .n_x4_out(n4), .n_x2_out(n2),
        .n_bus_out(nb), .n_src_out(np));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic setc(input ocs_pkg::ocs_cfg_t v);
        @(posedge clk_in);
        cfg <= v;
        cyc(3);
        @(negedge clk_in);
    endtask

    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask

    // Counts derived clock edges over 2500 cycles
    task automatic chk_rate(input string nm, input int e);
        @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        cyc(2500);
        @(negedge clk_in);
        `CHK(nm, e, n4, 2)
        `CHK("times-two rate", e / 2, n2, 1)
        `CHK("bus rate", e / 4, nb, 1)
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        cyc(50000);
        fail_count++;
        $display("watchdog expired");
        final_report();
    end

    initial
    begin
        cyc(8);
        sys_rst_in <= 1'b0;
        @(negedge clk_in);
        `CHK("engaged", 1'b0, st.external_clock_engaged, 0)
        `CHK("primary en", 1'b0, pen, 0)
        `CHK("amps", 3'h0, amps, 0)
        `CHK("pin oe", 1'b0, spoe, 0)
        chk_rate("default rate", 128);
        tend("reset");

        for (int i = 0; i < 4; i++)
        begin
            c.internal_frequency_select = i[1:0];
            setc(c);
            chk_rate("internal rate", 2500 * fr[i < 3 ? i : 2] / 250000);
        end
        tend("frequency codes");

        c.internal_frequency_select = ocs_pkg::IFS_12M8;
        c.internal_trim_value = 8'hFF;
        setc(c);
        chk_rate("slow trim", 128 * (512 - 127) / 512);
        hi = n4;
        c.internal_trim_value = 8'h00;
        setc(c);
        chk_rate("fast trim", 128 * (512 + 128) / 512);
        lo = n4;
        `CHK("trim order", 1'b1, hi < lo, 0)
        c.internal_trim_value = 8'h80;
        tend("trim");

        for (int m = 0; m < 8; m++)
        begin
            c.source_select = m[2:1];
            c.secondary_pin_clock_out_enable = m[0];
            setc(c);
            `CHK("primary en", m[2:1] != 0, pen, 0)
            `CHK("rc en", m[2:1] == 2, rcen, 0)
            `CHK("amps", m[2:1] == 3 ? 3'h1 : 3'h0, amps, 0)
            `CHK("pin oe", oe_exp[m], spoe, 0)
            `CHK("pin out", m > 5 ? !src : oe_exp[m] & x4, spo, 0)
            `CHK("status", {2'b01, oe_exp[m] && m < 6}, st, 0)
        end
        tend("pin modes");

        for (int r = 0; r < 4; r++)
        begin
            c.crystal_range_select = r[1:0];
            setc(c);
            `CHK("amp select", r < 3 ? 3'(1 << r) : 3'h0, amps, 0)
        end
        c.crystal_range_select = ocs_pkg::XR_1M_8M;
        setc(c);
        @(posedge clk_in);
        stop_en <= 1'b0;
        cyc(2);
        @(negedge clk_in);
        `CHK("stopped amps", 3'h0, amps, 0)
        @(posedge clk_in);
        keep <= 1'b1;
        cyc(2);
        @(negedge clk_in);
        `CHK("kept amps", 3'h2, amps, 0)
        @(posedge clk_in);
        stop_en <= 1'b1;
        keep    <= 1'b0;
        tend("stop gating");

        c.source_select = ocs_pkg::SRC_EXT;
        c.crystal_range_select = ocs_pkg::XR_8M_32M;
        setc(c);
        @(posedge clk_in);
        run <= 1'b1;
        cyc(100);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        @(posedge clk_in);
        c.external_clock_request = 1'b1;
        cfg <= c;
        for (k = 0; k < 200 && st.external_clock_engaged !== 1'b1; k++)
            @(negedge clk_in);
        `CHK("engaged", 1'b1, st.external_clock_engaged, 0)
        `CHK("two edges first", 1'b1, np >= 2, 0)
        `CHK("int still on", 1'b1, st.internal_osc_running, 0)
        @(negedge clk_in);
        `CHK("int stopped", 1'b0, st.internal_osc_running, 0)
        `CHK("ext pin oe", 1'b0, spoe, 0)
        chk_rate("external rate", 250);
        tend("switch out");

        c.source_select = ocs_pkg::SRC_INT;
        c.external_clock_request = 1'b0;
        c.internal_frequency_select = ocs_pkg::IFS_8M;
        @(posedge clk_in);
        cfg <= c;
        for (k = 0; k < 200 && st.external_clock_engaged !== 1'b0; k++)
            @(negedge clk_in);
        `CHK("disengaged", 1'b0, st.external_clock_engaged, 0)
        `CHK("int restarted", 1'b1, st.internal_osc_running, 0)
        chk_rate("return rate", 80);
        tend("switch back");
        @(posedge clk_in);
        ce_in <= 1'b0;
        chk_rate("frozen x4", 0);
        @(posedge clk_in);
        ce_in <= 1'b1;
        tend("clock enable");
        final_report();
    end
endmodule

`default_nettype wire
